// File: tmc_defines.svh
// offsets, field positions, reset values and timing figures of the heat monitor
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
`define TMC_ADDR_W          4
`define TMC_CTRL_OFS        4'h0
`define TMC_STATUS_OFS      4'h4
`define TMC_MASK_OFS        4'h8
`define TMC_LIVE_OFS        4'hc
`define TMC_CTRL_EN_BIT     0
`define TMC_CTRL_AON_BIT    1
`define TMC_CTRL_SEL_BIT    2
`define TMC_CTRL_CODE_LSB   4
`define TMC_CTRL_CODE_MSB   8
`define TMC_NFLAG           7
`define TMC_SD_IDX          6
`define TMC_CTRL_RST        9'h000
`define TMC_MASK_RST        7'h00
`define TMC_THR_80          8'h50
`define TMC_THR_95          8'h5f
`define TMC_THR_110         8'h6e
`define TMC_THR_125         8'h7d
`define TMC_THR_140         8'h8c
`define TMC_THR_155         8'h9b
`define TMC_THR_SD          8'ha5
`define TMC_WARN_HYS        8'h05
`define TMC_SD_HYS          8'h0f
`define TMC_CODE_HIZ        5'h00
`define TMC_CODE_DIE_HEAT   5'h07
`define TMC_CLK_PERIOD_NS   100
`define TMC_DEBOUNCE_NS     10000
`define TMC_WINDOW_US       450
`define TMC_INTERVAL_US     3000
`define TMC_DB_W            7
`define TMC_DB_CYC          (`TMC_DEBOUNCE_NS / `TMC_CLK_PERIOD_NS)
`define TMC_WINDOW_CYC      ((`TMC_WINDOW_US * 1000) / `TMC_CLK_PERIOD_NS)
`define TMC_INTERVAL_CYC    ((`TMC_INTERVAL_US * 1000) / `TMC_CLK_PERIOD_NS)
`endif

// File: tmc_host_model.sv
// host processor model: avalon master that reaches the flag registers
`timescale 1ns/1ps
module tmc_host_model (
  input  wire logic        clk_in,
  input  wire logic        waitrequest_in,
  input  wire logic [31:0] readdata_in,
  output logic      [3:0]  address_out,
  output logic             read_out,
  output logic             write_out,
  output logic      [31:0] writedata_out,
  output logic             hung_out
);
  // idle bus at time zero
  initial begin
    address_out   = 4'h0;
    read_out      = 1'b0;
    write_out     = 1'b0;
    writedata_out = 32'h0;
    hung_out      = 1'b0;
  end
  // one transfer: request held until waitrequest is sampled low at an edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_in);
    address_out   <= a;
    read_out      <= !w;
    write_out     <= w;
    writedata_out <= d;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_in);
      if (waitrequest_in === 1'b0) break;
    end
    q = readdata_in;
    read_out  <= 1'b0;
    write_out <= 1'b0;
    if (n == 40) hung_out = 1'b1; // seen by the caller as soon as the task returns
  endtask
endmodule // tmc_host_model

// File: tmc_pkg.sv
// types shared by the heat monitor control block
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_MODE_OFF    = 2'b00,
    TMC_MODE_ALWAYS = 2'b01,
    TMC_MODE_SAMPLE = 2'b10
  } tmc_mode_t;
endpackage

// File: tmc_thermal_monitor_control.sv
// heat monitor control: thresholds, debounce, sampling, events, selector pin
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "tmc_defines.svh"
module tmc_thermal_monitor_control
  import tmc_pkg::*;
#(
  parameter int WINDOW_CYC   = `TMC_WINDOW_CYC,
  parameter int INTERVAL_CYC = `TMC_INTERVAL_CYC
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  ce_in,
  input  wire logic [`TMC_ADDR_W-1:0] avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  output logic      [31:0]           avs_readdata_out,
  output logic                       avs_waitrequest_out,
  input  wire logic [7:0]            temp_code_in,
  input  wire logic                  sys_run_in,
  input  wire logic                  sys_standby_in,
  input  wire logic                  power_good_in,
  output logic                       sensor_power_out,
  output logic                       shutdown_out,
  output logic                       interrupt_out_n,
  output logic                       power_good_pin_one_out,
  output logic                       power_good_pin_one_oe_out,
  output logic                       die_heat_voltage_route_out
);

  localparam int DB_CYC = `TMC_DB_CYC;
  localparam logic [`TMC_DB_W-1:0] DB_LAST = `TMC_DB_W'(DB_CYC - 1);
  localparam logic [14:0] WIN_LAST = 15'(WINDOW_CYC);
  localparam logic [14:0] INT_LAST = 15'(INTERVAL_CYC - 1);

  logic [8:0]                ctrl;
  logic [`TMC_NFLAG-1:0]     status;
  logic [`TMC_NFLAG-1:0]     mask;
  logic [`TMC_NFLAG-1:0]     live;
  logic [`TMC_NFLAG-1:0]     raw;
  logic [`TMC_NFLAG-1:0]     rise;
  logic [14:0]               samp_cnt;
  logic [`TMC_DB_W-1:0]      db_cnt [`TMC_NFLAG];
  tmc_mode_t                 mode;
  logic                      sys_on;
  logic                      take;
  logic                      heat_watch_enable;
  logic                      heat_watch_always_on;
  logic                      analog_selector_enable;
  logic [4:0]                analog_channel_code;
  logic                      sel_active;
  logic [`TMC_NFLAG-1:0]     next_status;

  assign heat_watch_enable      = ctrl[`TMC_CTRL_EN_BIT];
  assign heat_watch_always_on   = ctrl[`TMC_CTRL_AON_BIT];
  assign analog_selector_enable = ctrl[`TMC_CTRL_SEL_BIT];
  assign analog_channel_code    = ctrl[`TMC_CTRL_CODE_MSB:`TMC_CTRL_CODE_LSB];
  assign sys_on                 = sys_run_in | sys_standby_in;
  assign sel_active             = analog_selector_enable & sys_on;
  // access completes at the edge where waitrequest is low
  assign take = (avs_read_in | avs_write_in) & ~avs_waitrequest_out;

  // monitor mode from enable, always-on and system state
  always_comb begin
    if (!heat_watch_enable || !sys_on) begin
      mode = TMC_MODE_OFF;
    end else if (sys_run_in && heat_watch_always_on) begin
      mode = TMC_MODE_ALWAYS;
    end else begin
      mode = TMC_MODE_SAMPLE;
    end
  end

  // bus handshake: one wait cycle per request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if (ce_in) begin
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & avs_waitrequest_out);
    end
  end

  // read data prepared during the wait cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (ce_in && avs_read_in && avs_waitrequest_out) begin
      unique case (avs_address_in)
        `TMC_CTRL_OFS:   avs_readdata_out <= {23'h000000, ctrl};
        `TMC_STATUS_OFS: avs_readdata_out <= {25'h0000000, status};
        `TMC_MASK_OFS:   avs_readdata_out <= {25'h0000000, mask};
        `TMC_LIVE_OFS:   avs_readdata_out <= {24'h000000, sensor_power_out, live};
        default:         avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // control register; selector fields writable only while system is on
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl <= `TMC_CTRL_RST;
    end else if (ce_in) begin
      if (take && avs_write_in && avs_address_in == `TMC_CTRL_OFS) begin
        ctrl[`TMC_CTRL_EN_BIT]  <= avs_writedata_in[`TMC_CTRL_EN_BIT];
        ctrl[`TMC_CTRL_AON_BIT] <= avs_writedata_in[`TMC_CTRL_AON_BIT];
        if (sys_on) begin
          ctrl[`TMC_CTRL_SEL_BIT] <= avs_writedata_in[`TMC_CTRL_SEL_BIT];
          ctrl[`TMC_CTRL_CODE_MSB:`TMC_CTRL_CODE_LSB] <=
            avs_writedata_in[`TMC_CTRL_CODE_MSB:`TMC_CTRL_CODE_LSB];
        end
      end
    end
  end

  // mask register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask <= `TMC_MASK_RST;
    end else if (ce_in && take && avs_write_in && avs_address_in == `TMC_MASK_OFS) begin
      mask <= avs_writedata_in[`TMC_NFLAG-1:0];
    end
  end

  // sticky events: write one clears, a new crossing wins over the clear
  always_comb begin
    next_status = status;
    if (take && avs_write_in && avs_address_in == `TMC_STATUS_OFS) begin
      next_status = status & ~avs_writedata_in[`TMC_NFLAG-1:0];
    end
    next_status = next_status | rise;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status <= '0;
    end else if (ce_in) begin
      status <= next_status;
    end
  end

  // interrupt pin, low while any unmasked event is latched
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      interrupt_out_n <= 1'b1;
    end else if (ce_in) begin
      interrupt_out_n <= ~|(next_status & ~mask);
    end
  end

  // sampling schedule: sensor powered for a window at the start of each interval
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      samp_cnt <= 15'h0000;
    end else if (ce_in) begin
      if (mode != TMC_MODE_SAMPLE || samp_cnt == INT_LAST) begin
        samp_cnt <= 15'h0000;
      end else begin
        samp_cnt <= samp_cnt + 15'h0001;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sensor_power_out <= 1'b0;
    end else if (ce_in) begin
      unique case (mode)
        TMC_MODE_OFF:    sensor_power_out <= 1'b0;
        TMC_MODE_ALWAYS: sensor_power_out <= 1'b1;
        TMC_MODE_SAMPLE: sensor_power_out <= (samp_cnt < WIN_LAST);
        default:         sensor_power_out <= 1'b0;
      endcase
    end
  end

  // comparators with hysteresis and two-way debounce; index 6 is shutdown
  generate
    for (genvar i = 0; i < `TMC_NFLAG; i++) begin : g_cmp
      localparam logic [7:0] THR = (i == 0) ? `TMC_THR_80 : (i == 1) ? `TMC_THR_95 :
                                   (i == 2) ? `TMC_THR_110 : (i == 3) ? `TMC_THR_125 :
                                   (i == 4) ? `TMC_THR_140 : (i == 5) ? `TMC_THR_155 :
                                   `TMC_THR_SD;
      localparam logic [7:0] HYS = (i == `TMC_SD_IDX) ? `TMC_SD_HYS : `TMC_WARN_HYS;
      localparam logic [7:0] REL = THR - HYS;
      // held above threshold minus hysteresis once set
      assign raw[i]  = live[i] ? (temp_code_in > REL) : (temp_code_in >= THR);
      // no event while the monitor is being switched off, since rise is gated by mode != TMC_MODE_OFF
      assign rise[i] = sensor_power_out & (mode != TMC_MODE_OFF) & raw[i] & ~live[i] & (db_cnt[i] == DB_LAST);

      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          live[i]   <= 1'b0;
          db_cnt[i] <= '0;
        end else if (ce_in) begin
          if (mode == TMC_MODE_OFF) begin
            live[i]   <= 1'b0;
            db_cnt[i] <= '0;
          end else if (!sensor_power_out || raw[i] == live[i]) begin
            db_cnt[i] <= '0;
          end else if (db_cnt[i] == DB_LAST) begin
            live[i]   <= raw[i];
            db_cnt[i] <= '0;
          end else begin
            db_cnt[i] <= db_cnt[i] + `TMC_DB_W'(1);
          end
        end
      end
    end
  endgenerate

  // shutdown request follows the debounced shutdown comparator
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shutdown_out <= 1'b0;
    end else if (ce_in) begin
      shutdown_out <= live[`TMC_SD_IDX];
    end
  end

  // shared pin: power-good or analog selector
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      power_good_pin_one_out     <= 1'b0;
      power_good_pin_one_oe_out  <= 1'b1;
      die_heat_voltage_route_out <= 1'b0;
    end else if (ce_in) begin
      power_good_pin_one_out     <= sel_active ? 1'b0 : power_good_in;
      power_good_pin_one_oe_out  <= ~sel_active;
      die_heat_voltage_route_out <= sel_active && (analog_channel_code == `TMC_CODE_DIE_HEAT);
    end
  end

  // checks
  sequence s_warn_settle;
    ce_in && sensor_power_out && raw[0] && !live[0] && db_cnt[0] == DB_LAST;
  endsequence

  a_event_on_rise: assert property (@(posedge clk_in) disable iff (rst_in)
    s_warn_settle |=> live[0] && status[0])
    else $error("warning crossing did not set event");
  a_live_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && live[0] && mode != TMC_MODE_OFF && temp_code_in > `TMC_THR_80 - `TMC_WARN_HYS |=> live[0])
    else $error("live flag dropped inside hysteresis band");
  a_debounce_time: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && $changed(live[0]) && $past(mode) != TMC_MODE_OFF |-> $past(db_cnt[0]) == DB_LAST)
    else $error("live flag changed before debounce elapsed");
  a_shutdown_follow: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && live[`TMC_SD_IDX] |=> shutdown_out)
    else $error("shutdown not raised");
  a_disable_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !heat_watch_enable |=> live == '0 && !sensor_power_out)
    else $error("monitor active while disabled");
  a_always_on: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && heat_watch_enable && sys_run_in && heat_watch_always_on |=> sensor_power_out)
    else $error("always-on sensor not powered");
  a_window_edge: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && mode == TMC_MODE_SAMPLE |=> sensor_power_out == ($past(samp_cnt) < WIN_LAST))
    else $error("sampling window wrong");
  a_standby_sample: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sys_standby_in && !sys_run_in && heat_watch_enable |-> mode == TMC_MODE_SAMPLE)
    else $error("standby not in sampling mode");
  a_irq_level: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in ##1 ce_in |-> interrupt_out_n == ~|($past(next_status) & ~$past(mask)))
    else $error("interrupt level wrong");
  a_pin_owner: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !sys_on |=> power_good_pin_one_oe_out && !die_heat_voltage_route_out)
    else $error("selector active outside on states");
  a_event_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && status[0] && !(take && avs_write_in && avs_address_in == `TMC_STATUS_OFS) |=> status[0])
    else $error("event flag lost without clear");

endmodule // tmc_thermal_monitor_control

// File: tmc_thermal_monitor_control_tb_top.sv
// self-checking bench for the heat monitor control block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module tmc_thermal_monitor_control_tb_top;
  import tmc_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  temp   = 8'h19;
  logic        run    = 1'b1;
  logic        stby   = 1'b0;
  logic        pg     = 1'b0;
  logic        ce     = 1'b1;
  logic [3:0]  addr;
  logic        rd_s, wr_s, wait_s, pwr, sd, irq_n, pin, pin_oe, route, hung;
  logic [31:0] wdata, rdata;
  int          num_errors = 0;
  int          num_checks = 0;
  int          thr[6] = '{80, 95, 110, 125, 140, 155};
  // clock at 10 MHz
  always #50 clk_in = ~clk_in;
  tmc_thermal_monitor_control #(.WINDOW_CYC(20), .INTERVAL_CYC(60)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .avs_address_in(addr),
    .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_s), .temp_code_in(temp),
    .sys_run_in(run), .sys_standby_in(stby), .power_good_in(pg),
    .sensor_power_out(pwr), .shutdown_out(sd), .interrupt_out_n(irq_n),
    .power_good_pin_one_out(pin), .power_good_pin_one_oe_out(pin_oe),
    .die_heat_voltage_route_out(route));
  tmc_host_model i_host (
    .clk_in(clk_in), .waitrequest_in(wait_s), .readdata_in(rdata), .address_out(addr),
    .read_out(rd_s), .write_out(wr_s), .writedata_out(wdata), .hung_out(hung));
  // bench helpers
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    i_host.xfer(1'b0, a, 32'h0, q);
    if (hung) final_report(); // a hung bus ends the run as a mismatch
  endtask
  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
    if (hung) final_report(); // a hung bus ends the run as a mismatch
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic count_pwr(output logic [7:0] c);
    c = 8'h0;
    repeat (60) begin
      @(posedge clk_in);
      c = c + {7'h0, pwr};
    end
  endtask
  task automatic final_report();
    `CHK(hung, 1'b0)
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    logic [31:0] q;
    logic [7:0]  c;
    int          t, h, e;
    void'($urandom(60554));
    cyc(8);
    rst_in <= 1'b0;
    `CHK({pin_oe, irq_n, sd, route}, 4'b1100)
    for (int a = 0; a < 16; a += 4) begin
      rd(a[3:0], q);
      `CHK(q, 32'h0)
    end
    wrr(4'h2, 32'h3);
    rd(4'h2, q);
    `CHK(q, 32'h0)
    rd(4'h0, q);
    `CHK(q, 32'h0)
    $display("test reset done");
    wrr(4'h0, 32'h3);
    cyc(5);
    `CHK(pwr, 1'b1)
    temp <= 8'd90;
    cyc(50);
    temp <= 8'd25;
    cyc(120);
    rd(4'h4, q);
    `CHK(q, 32'h0)
    $display("test debounce done");
    t = 80 + ($urandom % 85);
    e = 0;
    h = 0;
    for (int i = 0; i < 6; i++) begin
      if (t >= thr[i]) begin
        e |= 1 << i;
        h = i;
      end
    end
    temp <= t[7:0];
    cyc(120);
    rd(4'hc, q);
    `CHK(q, 32'(e | 32'h80))
    rd(4'h4, q);
    `CHK(q, 32'(e))
    `CHK(irq_n, 1'b0)
    wrr(4'h8, 32'h7f);
    cyc(2);
    `CHK(irq_n, 1'b1)
    wrr(4'h8, 32'h0);
    wrr(4'h4, 32'h3f);
    cyc(2);
    rd(4'h4, q);
    `CHK(q, 32'h0)
    `CHK(irq_n, 1'b1)
    $display("test events done");
    temp <= 8'(thr[h] - 4);
    cyc(120);
    rd(4'hc, q);
    `CHK(q, 32'(e | 32'h80))
    temp <= 8'(thr[h] - 5);
    cyc(120);
    rd(4'hc, q);
    `CHK(q, 32'((e & ~(1 << h)) | 32'h80))
    $display("test hysteresis done");
    temp <= 8'd170;
    cyc(120);
    `CHK(sd, 1'b1)
    rd(4'h4, q);
    `CHK(q[6], 1'b1)
    temp <= 8'd151;
    cyc(120);
    `CHK(sd, 1'b1)
    temp <= 8'd150;
    cyc(120);
    `CHK(sd, 1'b0)
    rd(4'h4, q);
    `CHK(q[6], 1'b1)
    $display("test shutdown done");
    temp <= 8'd25;
    wrr(4'h0, 32'h1);
    cyc(60);
    count_pwr(c);
    `CHK(c, 8'd20)
    run  <= 1'b0;
    stby <= 1'b1;
    wrr(4'h0, 32'h3);
    cyc(60);
    count_pwr(c);
    `CHK(c, 8'd20)
    wrr(4'h0, 32'h0);
    cyc(5);
    count_pwr(c);
    `CHK(c, 8'd0)
    $display("test sampling done");
    pg <= 1'($urandom % 2);
    wrr(4'h0, 32'h74);
    cyc(3);
    `CHK({pin_oe, route}, 2'b01)
    wrr(4'h0, 32'h34);
    cyc(3);
    `CHK({pin_oe, route}, 2'b00)
    wrr(4'h0, 32'h04);
    cyc(3);
    `CHK({pin_oe, route}, 2'b00)
    wrr(4'h0, 32'h0);
    cyc(3);
    `CHK({pin_oe, pin}, {1'b1, pg})
    // clock enable low freezes the pin register
    ce <= 1'b0;
    pg <= ~pg;
    cyc(3);
    `CHK(pin, ~pg)
    ce <= 1'b1;
    cyc(3);
    `CHK(pin, pg)
    stby <= 1'b0;
    wrr(4'h0, 32'h74);
    cyc(3);
    `CHK({pin_oe, route}, 2'b10)
    rd(4'h0, q);
    `CHK(q, 32'h0)
    $display("test selector done");
    final_report();
  end
endmodule // tmc_thermal_monitor_control_tb_top
